// ==== sarcr_regs.svh ====
`ifndef SARCR_REGS_SVH
`define SARCR_REGS_SVH
// ==========================================
// code constants
`define SARCR_CODE_MAX   24'h7F_FFFF
`define SARCR_CODE_MIN   24'h80_0000
`define SARCR_GAIN_UNITY 16'h8000
`define SARCR_GAIN_SHIFT 15
`define SARCR_OFS_RST    24'h00_0000
`define SARCR_CM_RST     8'h00
// ==========================================
// timing
`define SARCR_CONV_NS     300
`define SARCR_CLK_NS      4
`define SARCR_CONV_CYC    ((`SARCR_CONV_NS + `SARCR_CLK_NS - 1) / `SARCR_CLK_NS)
`endif

// ==== sarcr_pkg.sv ====
package sarcr_pkg;
	// ==========================================
	// sample fed into the core on adc_sample and held at conversion start
	typedef struct packed {
		logic [23:0] diff;
		logic [7:0]  cm;
	} sarcr_sample_t;

	// ==========================================
	// processing controls
	typedef struct packed {
		logic        ofs_en;
		logic        gain_en;
		logic [23:0] ofs;
		logic [15:0] gain;
	} sarcr_cfg_t;

	typedef enum logic [2:0] {
		SARCR_ACQ  = 3'b001,
		SARCR_CONV = 3'b010,
		SARCR_PROC = 3'b100
	} sarcr_state_t;
endpackage : sarcr_pkg

// ==== sarcr_fifo.sv ====
`timescale 1ns/1ps
module sarcr_fifo
	import sarcr_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// refuse sizes that the pointer wrap cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
		$error("sarcr_fifo: depth must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} sarcr_fifo_st_t;

	sarcr_fifo_st_t st_ff;
	sarcr_fifo_st_t nxt_st;
	logic           push;
	logic           pop;

	// ==========================================
	// flags
	assign in_ready  = (st_ff.wp - st_ff.rp) != (AW+1)'(DEPTH);
	assign out_valid = st_ff.wp != st_ff.rp;
	assign out_data  = st_ff.mem[st_ff.rp[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// next state
	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.mem[st_ff.wp[AW-1:0]] = in_data;
			nxt_st.wp = st_ff.wp + 1'b1;
		end
		if (pop)
			nxt_st.rp = st_ff.rp + 1'b1;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			st_ff <= '0;
		else if (ce)
			st_ff <= nxt_st;
	end
endmodule : sarcr_fifo

// ==== sarcr_core.sv ====
// How it works
// - alternates acquisition (tracking inputs) and conversion phases
// - a convert_start rising edge in acquisition, with pwr_down low, starts a conversion; host must supply it
// - that edge raises busy; busy falls once conversion completes
// - each conversion yields 24-bit difference and 8-bit common-mode codes
// - result optionally processed, then queued in a FIFO_DEPTH-entry buffer feeding readout
// - difference code is two's complement
// - +FS-1 is 7FFFFF, zero 000000, -FS 800000, -1 FFFFFF
// - offset or gain overflow saturates to signed 24-bit range
// - no latency: each queued result belongs to its own conversion; readout takes the oldest unread first
// - first conversion after power-down already valid
// - processing features switch only via control settings
// - busy high at conversion start, low when it finishes
// - with select low, host serial clock shifts stored result out
`timescale 1ns/1ps
`include "sarcr_regs.svh"
module sarcr_core
	import sarcr_pkg::*;
#(
	parameter int CONV_CYC   = `SARCR_CONV_CYC,
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic          clk_sys,
	input  wire logic          nrst,
	input  wire logic          ce,
	input  wire logic          convert_start,
	input  wire logic          pwr_down,
	input  wire sarcr_sample_t adc_sample,
	input  wire sarcr_cfg_t    cfg,
	input  wire logic          sck,
	input  wire logic          cs_n,
	output logic               busy_or_echo_clock_pin,
	output logic               tracking,
	output logic               sdo,
	output logic               sample_lost
);
	localparam int CW = $clog2(CONV_CYC + 1);

	// refuse a zero-length conversion or a buffer too small to wrap
	if (CONV_CYC < 1 || FIFO_DEPTH < 2) begin : g_bad_param
		$error("sarcr_core: bad parameters");
	end

	typedef struct packed {
		sarcr_state_t  state;
		logic [CW-1:0] cnt;
		logic          cnv_d;
		logic          busy;
		sarcr_sample_t held;
		logic [31:0]   shreg;
		logic [31:0]   last;
		logic          sck_d;
		logic          cs_d;
		logic          sdo;
		logic          lost;
	} sarcr_st_t;

	sarcr_st_t     st_ff;
	sarcr_st_t     nxt_st;
	logic          cnv_rise;
	logic          push;
	logic          push_ready;
	logic          out_valid;
	logic          out_ready;
	logic [31:0]   out_word;
	logic [23:0]   proc_diff;
	logic [31:0]   push_word;

	// ==========================================
	// digital post-processing with saturation
	function automatic logic [23:0] sarcr_proc(input logic [23:0] code, input sarcr_cfg_t c);
		logic signed [41:0] prod;
		logic signed [42:0] sum;
		logic signed [24:0] g;
		prod = 42'(signed'(code));
		g    = 25'({1'b0, c.gain});
		if (c.gain_en) begin
			prod = 42'(signed'(code) * g) >>> `SARCR_GAIN_SHIFT;
		end
		sum = 43'(prod);
		if (c.ofs_en) begin
			sum = sum + 43'(signed'(c.ofs));
		end
		if (sum > 43'(signed'(`SARCR_CODE_MAX)))
			sarcr_proc = `SARCR_CODE_MAX;
		else if (sum < 43'(signed'(`SARCR_CODE_MIN)))
			sarcr_proc = `SARCR_CODE_MIN;
		else
			sarcr_proc = sum[23:0];
	endfunction : sarcr_proc

	// ==========================================
	// edge detect and outputs
	assign cnv_rise               = convert_start && !st_ff.cnv_d;
	assign busy_or_echo_clock_pin = st_ff.busy;
	assign tracking               = st_ff.state == SARCR_ACQ;
	assign sdo                    = st_ff.sdo;
	assign sample_lost            = st_ff.lost;
	assign proc_diff              = sarcr_proc(st_ff.held.diff, cfg);
	assign push_word              = {proc_diff, st_ff.held.cm};
	assign push                   = st_ff.state == SARCR_PROC;
	assign out_ready              = st_ff.cs_d && !cs_n; // load on frame start

	// ==========================================
	// result buffer between conversion and readout
	sarcr_fifo #(
		.WIDTH(32),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.ce       (ce),
		.in_valid (push),
		.in_ready (push_ready),
		.in_data  (push_word),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data (out_word)
	);

	// ==========================================
	// conversion sequencer and serial shifter
	always_comb begin
		nxt_st       = st_ff;
		nxt_st.cnv_d = convert_start;
		nxt_st.sck_d = sck;
		nxt_st.cs_d  = cs_n;
		unique case (st_ff.state)
			SARCR_ACQ: begin
				if (cnv_rise && !pwr_down) begin
					nxt_st.state = SARCR_CONV;
					nxt_st.busy  = 1'b1;
					nxt_st.cnt   = CW'(CONV_CYC - 1);
					nxt_st.held  = adc_sample; // sample held at edge
				end
			end
			SARCR_CONV: begin
				if (st_ff.cnt == '0)
					nxt_st.state = SARCR_PROC;
				else
					nxt_st.cnt = st_ff.cnt - 1'b1;
			end
			SARCR_PROC: begin
				// latch this very sample, no pipeline
				nxt_st.state = SARCR_ACQ;
				nxt_st.busy  = 1'b0;
				if (!push_ready)
					nxt_st.lost = 1'b1;
			end
		endcase
		// readout: load on select fall, shift on sck falling edge
		// an empty buffer repeats the last word loaded, not the shifted-out remains
		if (out_ready) begin
			nxt_st.shreg = out_valid ? out_word : st_ff.last;
			nxt_st.sdo   = out_valid ? out_word[31] : st_ff.last[31];
			if (out_valid)
				nxt_st.last = out_word;
			// a result dropped in this same cycle keeps the flag set
			nxt_st.lost  = st_ff.state == SARCR_PROC && !push_ready;
		end else if (!cs_n && st_ff.sck_d && !sck) begin
			nxt_st.shreg = {st_ff.shreg[30:0], 1'b0};
			nxt_st.sdo   = st_ff.shreg[30];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff       <= '0;
			st_ff.state <= SARCR_ACQ;
			st_ff.cs_d  <= 1'b1;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end
endmodule : sarcr_core

// ==== sarcr_core_properties.sv ====
`timescale 1ns/1ps
// ==========
// port checks on the converter core
module sarcr_chk
	import sarcr_pkg::*;
#(
	parameter int CONV_CYC = 2
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic convert_start,
	input wire logic pwr_down,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic busy_or_echo_clock_pin,
	input wire logic tracking,
	input wire logic sdo,
	input wire logic sample_lost
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire        busy = busy_or_echo_clock_pin;
	logic [7:0] busy_n_ff;
	logic [2:0] since_ff;
	// busy length, cycles since a serial event
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			busy_n_ff <= 8'h00;
			since_ff <= 3'h7;
		end else begin
			busy_n_ff <= busy ? busy_n_ff + 8'h01 : 8'h00;
			since_ff <= ($fell(sck) || $fell(cs_n)) ? 3'h0 : since_ff + 3'(since_ff != 3'h7);
		end
	end
	a_start_busy: assert property ($rose(convert_start) && !busy && !pwr_down |=> busy) else $error("no busy");
	a_busy_cause: assert property ($rose(busy) |-> $past(convert_start) && !$past(convert_start, 2)) else $error("busy without start");
	a_busy_len: assert property ($fell(busy) |-> busy_n_ff == CONV_CYC + 1) else $error("busy length");
	a_track_phase: assert property (tracking != busy) else $error("phase");
	a_pwr_hold: assert property (pwr_down && !busy |=> !busy) else $error("start in power-down");
	a_sdo_moves: assert property ($changed(sdo) |-> since_ff < 3'h4) else $error("sdo moved");
	a_lost_cause: assert property ($rose(sample_lost) |-> $past(busy)) else $error("lost");
	a_lost_hold: assert property (sample_lost && cs_n ##1 cs_n |-> sample_lost) else $error("lost cleared");
endmodule : sarcr_chk
bind sarcr_core sarcr_chk #(.CONV_CYC(CONV_CYC)) i_sarcr_chk (.clk_sys, .nrst, .convert_start, .pwr_down, .sck,
	.cs_n, .busy_or_echo_clock_pin, .tracking, .sdo, .sample_lost);

// ==== sarcr_host.sv ====
`timescale 1ns/1ps
// ==========
// host side: start pulses and serial readout
module sarcr_host (
	input  wire logic clk_sys,
	input  wire logic busy,
	input  wire logic sdo,
	output logic      convert_start,
	output logic      sck,
	output logic      cs_n
);
	initial {convert_start, sck, cs_n} = 3'b001;
	// one start pulse, then wait for busy low
	task conv();
		int n;
		@(posedge clk_sys) convert_start <= 1'b1;
		@(posedge clk_sys) convert_start <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (busy !== 1'b0 && n < 64);
	endtask : conv
	// one word, msb first, sampled before each sck fall
	task rd(output logic [31:0] w);
		@(posedge clk_sys) cs_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		for (int i = 31; i >= 0; i--) begin
			@(negedge clk_sys) w[i] = sdo;
			@(posedge clk_sys) sck <= 1'b1;
			repeat (2) @(posedge clk_sys);
			sck <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
		cs_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
	endtask : rd
endmodule : sarcr_host

// ==== testbench.sv ====
`timescale 1ns/1ps
// ==========
// bench top
module testbench;
	import sarcr_pkg::*;
	logic          clk_sys, nrst, ce, pwr_down, convert_start, sck, cs_n, busy, tracking, sdo, sample_lost;
	sarcr_sample_t adc_sample;
	sarcr_cfg_t    cfg;
	logic [31:0]   w;
	int            num_errors = 0, checked = 0, cyc = 0;
	sarcr_core #(.CONV_CYC(2), .FIFO_DEPTH(16)) i_sarcr_core (.clk_sys, .nrst, .ce, .convert_start, .pwr_down,
		.adc_sample, .cfg, .sck, .cs_n, .busy_or_echo_clock_pin(busy), .tracking, .sdo, .sample_lost);
	sarcr_host i_sarcr_host (.clk_sys, .busy, .sdo, .convert_start, .sck, .cs_n);
	// clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end
	task close_out();
		if (num_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	task chk(logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// expected code after gain, offset and clamp
	function automatic logic [23:0] proc(logic [23:0] d, o, logic [15:0] g, logic [1:0] en);
		longint v;
		v = longint'($signed(d));
		if (en[0]) v = (v * longint'(g)) >>> 15;
		if (en[1]) v = v + longint'($signed(o));
		return v > 64'sh7F_FFFF ? 24'h7F_FFFF : v < -64'sh80_0000 ? 24'h80_0000 : v[23:0];
	endfunction : proc
	// one conversion and one readout
	task one(logic [23:0] d, o, logic [15:0] g, logic [1:0] en);
		@(posedge clk_sys);
		adc_sample <= '{d, d[7:0] ^ 8'hA5};
		cfg <= '{en[1], en[0], o, g};
		i_sarcr_host.conv();
		i_sarcr_host.rd(w);
		chk(w, {proc(d, o, g, en), d[7:0] ^ 8'hA5});
	endtask : one
	// starts ignored in power-down
	task t_pwr();
		pwr_down <= 1'b1;
		i_sarcr_host.conv();
		chk({31'h0, busy}, 32'h0);
		@(posedge clk_sys) pwr_down <= 1'b0;
		one(24'h12_3456, 24'h0, 16'h8000, 2'b00);
	endtask : t_pwr
	// table codes pass unchanged
	task t_codes();
		logic [23:0] c [5] = '{24'h7F_FFFF, 24'h00_0000, 24'h80_0000, 24'hFF_FFFF, 24'h80_0001};
		foreach (c[k]) one(c[k], 24'h0, 16'h0, 2'b00);
	endtask : t_codes
	// clamp at both ends
	task t_sat();
		one(24'h7F_FFFF, 24'h00_0001, 16'h8000, 2'b10);
		one(24'h80_0000, 24'hFF_FFFF, 16'h8000, 2'b10);
		one(24'h40_1000, 24'h0, 16'hFFFF, 2'b01);
		one(24'h80_0000, 24'h0, 16'hFFFF, 2'b11);
		one(24'h7F_FFFF, 24'h0, 16'h7E00, 2'b01);
		one(24'h7F_FFFF, 24'h00_0100, 16'h4000, 2'b00);
	endtask : t_sat
	// overfill with no readout, then drain in order
	task t_fifo();
		for (int i = 0; i < 17; i++) begin
			@(posedge clk_sys) adc_sample <= '{24'(i), 8'(i)};
			i_sarcr_host.conv();
		end
		chk({31'h0, sample_lost}, 32'h1);
		for (int i = 0; i < 17; i++) begin
			i_sarcr_host.rd(w);
			chk(w, {24'(i < 16 ? i : 15), 8'(i < 16 ? i : 15)});
		end
		chk({31'h0, sample_lost}, 32'h0);
	endtask : t_fifo
	// main sequence
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		pwr_down = 1'b0;
		adc_sample = '0;
		cfg = '0;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		t_pwr();
		t_codes();
		t_sat();
		t_fifo();
		close_out();
	end
endmodule : testbench
